// ===== tb/pcc_far_model.sv
// Far side: count sensors, control contacts and the serial host.
// Driven by task calls; every line changes just after a rising edge.
module pcc_far_model (
  // Clock.
  input  wire logic       sys_clk,
  // Sensor and contact lines.
  output logic            count_a,
  output logic            count_b,
  output logic [3:0]      ctrl_in,
  // Host message.
  output logic            msg_valid,
  output logic [7:0]      msg_id
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit 0 is A, bit 1 is B, bits 5:2 are the four contacts.
  logic [5:0] line_q = 6'h00;
  int         ph_q   = 0;
  assign count_a = line_q[0];
  assign count_b = line_q[1];
  assign ctrl_in = line_q[5:2];
  initial begin
    msg_valid = 1'b0;
    msg_id    = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Each level stands at least nine cycles, longer than the contact filter.
  task automatic level(input int idx, input logic v);
    @(posedge sys_clk);
    line_q[idx] <= v;
    hold(8);
  endtask
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      level(idx, 1'b1);
      level(idx, 1'b0);
    end
  endtask
  // Quarter steps; a positive count has A leading B.
  task automatic quad(input int steps);
    repeat (steps < 0 ? -steps : steps) begin
      ph_q = (ph_q + (steps < 0 ? 3 : 1)) % 4;
      @(posedge sys_clk);
      line_q[1:0] <= {ph_q inside {2, 3}, ph_q inside {1, 2}};
      hold(8);
    end
  endtask
  // The identifier byte is stale-inverted once the message is gone.
  task automatic send(input logic [7:0] id);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    msg_id    <= id;
    @(posedge sys_clk);
    msg_valid <= 1'b0;
    msg_id    <= ~id;
  endtask
endmodule

// ===== tb/pcc_top_monitor.sv
// Checker for the preset count control top: program entry, refusals, turnaround.
// Sees only top-level ports and is bound to every pcc_top.
module pcc_top_monitor
  import pcc_pkg::*;
#(
  parameter int unsigned ENTER_CYC  = 50,
  parameter int unsigned TSHORT_CYC = 5,
  parameter int unsigned TLONG_CYC  = 20
) (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       rst,
  // Bus.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       pready,
  // Keys, serial gating, outputs.
  input wire logic       run_program_key,
  input wire logic       enter_key,
  input wire logic       msg_valid,
  input wire logic       reply_go,
  input wire logic [2:0] out_on,
  input wire logic       program_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ages saturate so that a long idle span never wraps into a false match.
  logic [7:0] run_age_q;
  logic [7:0] ent_age_q;
  logic [7:0] msg_age_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_age_q <= 8'hFF;
      ent_age_q <= 8'hFF;
      msg_age_q <= 8'hFF;
    end else begin
      run_age_q <= run_program_key ? 8'h00 : run_age_q + 8'(run_age_q != 8'hFF);
      ent_age_q <= enter_key ? 8'h00 : ent_age_q + 8'(ent_age_q != 8'hFF);
      msg_age_q <= msg_valid ? 8'h00 : msg_age_q + 8'(msg_age_q != 8'hFF);
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_rst_off;
    $past(rst) |-> out_on == 3'b000;
  endproperty
  property p_prog_off;
    program_mode && $past(program_mode) |-> out_on == 3'b000;
  endproperty
  property p_prog_enter;
    $rose(program_mode) |-> ent_age_q <= 8'h08;
  endproperty
  property p_prog_window;
    $rose(program_mode) |-> run_age_q <= ENTER_CYC + 8;
  endproperty
  property p_refuse_prog;
    psel && penable && !pready && pwrite && program_mode && paddr == REG_MODE |=> pslverr;
  endproperty
  property p_err_cause;
    pslverr |-> $past(penable);
  endproperty
  property p_reply_early;
    $rose(reply_go) |-> msg_age_q >= TSHORT_CYC - 1;
  endproperty
  property p_reply_late;
    $rose(reply_go) |-> msg_age_q <= TLONG_CYC + 8;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("output on after reset");
  a_prog_off: assert property (p_prog_off) else $error("output on in program");
  a_prog_enter: assert property (p_prog_enter) else $error("program without enter");
  a_prog_window: assert property (p_prog_window) else $error("enter too late");
  a_refuse_prog: assert property (p_refuse_prog) else $error("write not refused");
  a_err_cause: assert property (p_err_cause) else $error("error without access");
  a_reply_early: assert property (p_reply_early) else $error("reply too early");
  a_reply_late: assert property (p_reply_late) else $error("reply unprompted");
  c_prog: cover property ($rose(program_mode));
  c_reply: cover property ($rose(reply_go));
  c_err: cover property (pslverr);
endmodule

bind pcc_top pcc_top_monitor #(
  .ENTER_CYC(ENTER_CYC), .TSHORT_CYC(TSHORT_CYC), .TLONG_CYC(TLONG_CYC)
) u_mon (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .pready(pready), .run_program_key(run_program_key),
  .enter_key(enter_key), .msg_valid(msg_valid), .reply_go(reply_go), .out_on(out_on),
  .program_mode(program_mode)
);

// ===== tb/test_preset_count_control.sv
// Self-checking bench for the preset count control top over APB.
// Keys come from here; sensors, contacts and host from the far-side model.
module test_preset_count_control
  import pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENTER = 50;
  logic        sys_clk;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [2:0]  keys_q  = 3'b000;
  logic [31:0] prdata, rd_v;
  logic        pready, pslverr, er_v, count_a, count_b, msg_valid, reply_go, program_mode;
  logic [3:0]  ctrl_in;
  logic [7:0]  msg_id;
  logic [2:0]  out_on;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          rep_n      = 0;
  int          exp_t[9]   = '{7, 9, 6, 4, 4, 7, 9, 6, 8};
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  pcc_top #(.ENTER_CYC(ENTER), .CHK_CYC(4), .TICK_CYC(4), .TSHORT_CYC(5), .TLONG_CYC(20),
    .DEB_CYC(3)) DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_a(count_a), .count_b(count_b), .ctrl_in(ctrl_in), .front_reset_key(keys_q[0]),
    .run_program_key(keys_q[1]), .enter_key(keys_q[2]), .msg_valid(msg_valid),
    .msg_id(msg_id), .reply_go(reply_go), .out_on(out_on), .program_mode(program_mode));
  pcc_far_model far (.sys_clk(sys_clk), .count_a(count_a), .count_b(count_b),
    .ctrl_in(ctrl_in), .msg_valid(msg_valid), .msg_id(msg_id));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts edges until the turnaround flag stands; 40 means no answer came.
  task automatic wait_reply(output int n);
    n = 0;
    while (reply_go !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic key(input int i);
    @(posedge sys_clk);
    keys_q[i] <= 1'b1;
    far.hold(4);
    keys_q[i] <= 1'b0;
    far.hold(4);
  endtask
  // Leaves the counter at 4 in the requested mode.
  task automatic warm(input logic [31:0] m);
    apb(1'b1, REG_MODE, 32'h1);
    far.pulse(2, 1);
    far.pulse(0, 4);
    apb(1'b1, REG_MODE, m);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(REG_MODE, RST_MODE);
    rchk(REG_OUTCFG0, RST_OUTCFG);
    chk(32'(out_on), 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(er_v), 32'h1);
    apb(1'b1, REG_INPUTS, 32'h0000_1432);
    warm(32'h0);
    far.level(2, 1'b1);
    far.pulse(0, 1);
    far.level(2, 1'b0);
    rchk(REG_COUNT, 32'h1);
    far.level(3, 1'b1);
    far.pulse(0, 2);
    rchk(REG_COUNT, 32'h0);
    far.level(3, 1'b0);
    far.pulse(0, 1);
    far.level(4, 1'b1);
    far.pulse(0, 2);
    rchk(REG_COUNT, 32'h1);
    far.level(4, 1'b0);
    far.pulse(0, 1);
    rchk(REG_COUNT, 32'h2);
    for (int m = 0; m < 9; m++) begin
      warm(32'(m));
      far.pulse(0, 1);
      far.level(1, 1'b1);
      far.pulse(0, 3);
      far.level(1, 1'b0);
      rchk(REG_COUNT, 32'(exp_t[m]));
    end
    for (int m = 3; m < 5; m++) begin
      warm(32'(m));
      far.quad(8);
      far.quad(-4);
      rchk(REG_COUNT, 32'(m + 2));
    end
    apb(1'b1, REG_PRESET, 32'h3);
    apb(1'b1, REG_OUTCFG0, 32'h0001_0024);
    apb(1'b1, REG_OUTCFG1, 32'h0001_0081);
    apb(1'b1, REG_OUTCFG2, 32'h0003_0042);
    apb(1'b1, REG_MODE, 32'h30);
    far.level(2, 1'b1);
    chk(32'(out_on), 32'h6);
    far.level(2, 1'b0);
    far.hold(8);
    chk(32'(out_on), 32'h2);
    far.pulse(1, 3);
    far.hold(16);
    chk(32'(out_on), 32'h3);
    rchk(REG_COUNT, 32'h3);
    far.pulse(5, 1);
    chk(32'(out_on), 32'h2);
    apb(1'b1, REG_INPUTS, 32'h0000_5432);
    far.level(5, 1'b1);
    apb(1'b1, REG_MODE, 32'h0);
    chk(32'(er_v), 32'h1);
    rchk(REG_MODE, 32'h30);
    apb(1'b1, REG_PRESET, 32'h5);
    rchk(REG_PRESET, 32'h5);
    far.level(5, 1'b0);
    apb(1'b1, REG_INPUTS, 32'h0000_6432);
    far.level(5, 1'b1);
    apb(1'b1, REG_PRESET, 32'h7);
    rchk(REG_PRESET, 32'h5);
    far.level(5, 1'b0);
    apb(1'b1, REG_MODE, 32'h0000_0230);
    key(0);
    rchk(REG_COUNT, 32'h5);
    key(1);
    far.hold(ENTER + 20);
    key(2);
    chk(32'(program_mode), 32'h0);
    key(1);
    key(2);
    chk(32'(program_mode), 32'h1);
    chk(32'(out_on), 32'h0);
    apb(1'b1, REG_MODE, 32'h0);
    chk(32'(er_v), 32'h1);
    key(1);
    chk(32'(program_mode), 32'h0);
    // Identifier 25 travels as its hexadecimal byte.
    apb(1'b1, REG_SERIAL, 32'h19);
    far.send(8'h25);
    wait_reply(rep_n);
    chk(32'(rep_n), 32'd40);
    far.send(8'h19);
    chk(32'(reply_go), 32'h0);
    wait_reply(rep_n);
    chk(32'(reply_go), 32'h1);
    chk(32'(rep_n), 32'd5);
    apb(1'b1, REG_SERIAL, 32'h0000_4019);
    far.send(8'h19);
    wait_reply(rep_n);
    chk(32'(rep_n), 32'd20);
    test_done();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
endmodule

// ===== verilog/pcc_pkg.sv
// Constants, register map and enumerations for the preset count control block.
// Assumes a single 125 MHz clock and an APB master that holds each request until pready.
package pcc_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned ENTER_WIN_S   = 5;
  localparam int unsigned ENTER_WIN_CYC = ENTER_WIN_S * CLK_HZ;
  localparam int unsigned CHECK_MS      = 2;
  localparam int unsigned CHECK_CYC     = CHECK_MS * (CLK_HZ / 1000);
  localparam int unsigned HUND_MS       = 10;
  localparam int unsigned HUND_CYC      = HUND_MS * (CLK_HZ / 1000);
  localparam int unsigned TURN_SHORT_MS = 2;
  localparam int unsigned TURN_LONG_MS  = 100;
  localparam int unsigned TURN_SHORT_CYC = TURN_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned TURN_LONG_CYC  = TURN_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC  = 4096;
  localparam int unsigned ID_MAX        = 99;
  localparam int unsigned PULSE_MIN     = 1;
  localparam int unsigned PULSE_MAX     = 9999;
  // Register byte offsets.
  localparam logic [7:0] REG_MODE    = 8'h00;
  localparam logic [7:0] REG_INPUTS  = 8'h04;
  localparam logic [7:0] REG_OUTCFG0 = 8'h08;
  localparam logic [7:0] REG_OUTCFG1 = 8'h0C;
  localparam logic [7:0] REG_OUTCFG2 = 8'h10;
  localparam logic [7:0] REG_PRESET  = 8'h14;
  localparam logic [7:0] REG_SERIAL  = 8'h18;
  localparam logic [7:0] REG_COUNT   = 8'h1C;
  localparam logic [7:0] REG_STATUS  = 8'h20;
  localparam logic [7:0] REG_SERCMD  = 8'h24;
  // Field positions.
  localparam int unsigned MODE_CM_LSB   = 0;
  localparam int unsigned MODE_LOAD_BIT = 4;
  localparam int unsigned MODE_AUTO_BIT = 5;
  localparam int unsigned MODE_KEY_LSB  = 8;
  localparam int unsigned OUT_REV_BIT   = 0;
  localparam int unsigned OUT_PUL_BIT   = 1;
  localparam int unsigned OUT_COIN_LSB  = 2;
  localparam int unsigned OUT_OCTL_LSB  = 4;
  localparam int unsigned OUT_CLR_LSB   = 6;
  localparam int unsigned OUT_DUR_LSB   = 16;
  localparam int unsigned SER_ID_LSB    = 0;
  localparam int unsigned SER_BAUD_LSB  = 8;
  localparam int unsigned SER_PAR_LSB   = 12;
  localparam int unsigned SER_TURN_BIT  = 14;
  localparam logic [31:0] RST_MODE    = 32'h0000_0000;
  localparam logic [31:0] RST_OUTCFG  = 32'h0001_0000;
  localparam logic [23:0] PRESET_MAX  = 24'h0F_423F;
  typedef enum logic [3:0] {
    PCC_CM_CADDSUB = 4'h0, PCC_CM_CADDADD = 4'h1, PCC_CM_CDIR = 4'h2,
    PCC_CM_QUAD1 = 4'h3, PCC_CM_QUAD2 = 4'h4, PCC_CM_SADDSUB = 4'h5,
    PCC_CM_SADDADD = 4'h6, PCC_CM_SDIR1 = 4'h7, PCC_CM_SDIR2 = 4'h8
  } pcc_cmode_t;
  typedef enum logic [2:0] {
    PCC_IN_OFF = 3'h0, PCC_IN_OUTPUT_CONTROL_EVENT = 3'h1, PCC_IN_EDGE = 3'h2, PCC_IN_LEVEL = 3'h3,
    PCC_IN_INHIBIT = 3'h4, PCC_IN_LOCK = 3'h5, PCC_IN_LOCKALL = 3'h6
  } pcc_infn_t;
  typedef enum logic [1:0] {
    PCC_ACT_NONE = 2'h0, PCC_ACT_PICK = 2'h1, PCC_ACT_DROP = 2'h2
  } pcc_act_t;
  typedef enum logic [1:0] {
    PCC_PAR_NONE = 2'h0, PCC_PAR_ODD = 2'h1, PCC_PAR_EVEN = 2'h2
  } pcc_par_t;
  typedef enum logic [1:0] {
    PCC_RUN = 2'b00, PCC_ARMED = 2'b01, PCC_PROG = 2'b11
  } pcc_pst_t;
endpackage

// ===== verilog/pcc_top.sv
// Preset count control: count decoding, counter, control inputs, three outputs
// and serial port settings, all reached over APB.
// Assumes pins synchronous-ish to sys_clk; a second flop stage is still added here.
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned ENTER_CYC  = ENTER_WIN_CYC,
  parameter int unsigned CHK_CYC    = CHECK_CYC,
  parameter int unsigned TICK_CYC   = HUND_CYC,
  parameter int unsigned TSHORT_CYC = TURN_SHORT_CYC,
  parameter int unsigned TLONG_CYC  = TURN_LONG_CYC,
  parameter int unsigned DEB_CYC    = DEBOUNCE_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Count inputs, control inputs and keys.
  input  wire logic        count_a,
  input  wire logic        count_b,
  input  wire logic [3:0]  ctrl_in,
  input  wire logic        front_reset_key,
  input  wire logic        run_program_key,
  input  wire logic        enter_key,
  // Serial message gating from the link logic.
  input  wire logic        msg_valid,
  input  wire logic [7:0]  msg_id,
  output logic             reply_go,
  // Outputs: relay, transistor 1, transistor 2.
  output logic [2:0]       out_on,
  output logic             program_mode
);
  localparam int unsigned DBW = $clog2(DEB_CYC + 1);

  typedef struct packed {
    logic [1:0]  sa, sb;
    logic [7:0]  sc;
    logic [1:0]  sk, sr, se;
    logic [DBW-1:0] da, db;
    logic        fa, fb;
    logic [6:0]  lvl;
    logic [31:0] mode, inputs, preset, serial;
    logic [2:0][31:0] ocfg;
    logic [23:0] count;
    logic        passed;
    logic [31:0] chk;
    logic [2:0]  on;
    logic [2:0][13:0] dur;
    logic [23:0] tick;
    logic        hund;
    pcc_pst_t    pst;
    logic [31:0] win;
    logic [23:0] turn;
    logic        busy, refused;
    logic [31:0] rdata;
    logic        err;
    logic        ack;
  } pcc_state_t;

  pcc_state_t s_q, s_d;

  logic        raw_a, raw_b, rise_a, fall_a, rise_b, fall_b;
  logic [4:0]  act_lvl, act_rise;
  logic        up, dn, octl, clr_edge, clr_hold, inhibit, lock, lockall;
  logic        contact, doubled, load_mode;
  logic        do_clr, coin;
  logic [23:0] clr_val;
  logic        wr, rd;
  logic        prog_ok, preset_ok;

  // One wait state lets read data and the error flag come from flops with pready.
  assign pready  = s_q.ack;
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.err;
  assign out_on  = s_q.on;
  assign program_mode = (s_q.pst == PCC_PROG);
  assign reply_go = s_q.busy && (s_q.turn == 24'h00_0000);

  assign contact   = (s_q.mode[MODE_CM_LSB +: 4] <= PCC_CM_CDIR);
  assign doubled   = (s_q.mode[MODE_CM_LSB +: 4] == PCC_CM_QUAD2) ||
                     (s_q.mode[MODE_CM_LSB +: 4] == PCC_CM_SDIR2);
  assign load_mode = s_q.mode[MODE_LOAD_BIT];
  assign raw_a = contact ? s_q.fa : s_q.sa[1];
  assign raw_b = contact ? s_q.fb : s_q.sb[1];
  assign rise_a = raw_a & ~s_q.lvl[6];
  assign fall_a = ~raw_a & s_q.lvl[6];
  assign rise_b = raw_b & ~s_q.lvl[5];
  assign fall_b = ~raw_b & s_q.lvl[5];
  assign act_lvl = {s_q.sk[1], s_q.sc[7], s_q.sc[5], s_q.sc[3], s_q.sc[1]};
  assign wr = psel && penable && pwrite && !s_q.ack;
  assign rd = psel && penable && !pwrite && !s_q.ack;
  assign prog_ok   = !lock && !lockall && (s_q.pst != PCC_PROG);
  assign preset_ok = !lockall;
  assign clr_val = load_mode ? s_q.preset[23:0] : 24'h00_0000;

  // Decode of count inputs into up and down pulses.
  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    unique case (s_q.mode[MODE_CM_LSB +: 4])
      PCC_CM_CADDSUB, PCC_CM_SADDSUB: begin
        up = rise_a;
        dn = rise_b;
      end
      PCC_CM_CADDADD, PCC_CM_SADDADD: begin
        up = rise_a | rise_b;
      end
      PCC_CM_CDIR, PCC_CM_SDIR1, PCC_CM_SDIR2: begin
        up = (rise_a | (doubled & fall_a)) & raw_b;
        dn = (rise_a | (doubled & fall_a)) & ~raw_b;
      end
      PCC_CM_QUAD1, PCC_CM_QUAD2: begin
        // Stepping on A edges with direction from B cancels jitter on either line.
        up = (rise_a & ~raw_b) | (doubled & fall_a & raw_b);
        dn = (fall_a & ~raw_b) | (doubled & rise_a & raw_b);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end

  // Control input functions combined over the four terminals and the key.
  always_comb begin
    logic [2:0] fn;
    fn = 3'h0;
    octl = 1'b0;
    clr_edge = 1'b0;
    clr_hold = 1'b0;
    inhibit = 1'b0;
    lock = 1'b0;
    lockall = 1'b0;
    act_rise = act_lvl & ~s_q.lvl[4:0];
    for (int i = 0; i < 5; i++) begin
      fn = (i == 4) ? s_q.mode[MODE_KEY_LSB +: 3] : s_q.inputs[i*4 +: 3];
      if (i == 4 && fn != PCC_IN_EDGE && fn != PCC_IN_LEVEL) begin
        fn = PCC_IN_OFF;
      end
      unique case (fn)
        PCC_IN_OUTPUT_CONTROL_EVENT:   octl     = octl | act_rise[i];
        PCC_IN_EDGE:    clr_edge = clr_edge | act_rise[i];
        PCC_IN_LEVEL:   clr_hold = clr_hold | act_lvl[i];
        PCC_IN_INHIBIT: inhibit  = inhibit | act_lvl[i];
        PCC_IN_LOCK:    lock     = lock | act_lvl[i];
        PCC_IN_LOCKALL: lockall  = lockall | act_lvl[i];
        default:        octl     = octl;
      endcase
    end
  end

  assign coin   = s_q.passed && (s_q.chk == 32'h0000_0000);
  assign do_clr = clr_edge | clr_hold | (coin & s_q.mode[MODE_AUTO_BIT]);

  always_comb begin
    logic [1:0] ev;
    s_d = s_q;
    ev = 2'b00;
    s_d.err = 1'b0;
    s_d.ack = psel && penable && !s_q.ack;
    // Two-stage synchronizers feed the filters and edge detectors.
    s_d.sa = {s_q.sa[0], count_a};
    s_d.sb = {s_q.sb[0], count_b};
    s_d.sc = {s_q.sc[6], ctrl_in[3], s_q.sc[4], ctrl_in[2],
              s_q.sc[2], ctrl_in[1], s_q.sc[0], ctrl_in[0]};
    s_d.sk = {s_q.sk[0], front_reset_key};
    s_d.sr = {s_q.sr[0], run_program_key};
    s_d.se = {s_q.se[0], enter_key};
    // A contact filter only accepts a level that stayed put for the full window.
    s_d.da = (s_q.sa[1] == s_q.fa) ? '0 : s_q.da + DBW'(1);
    if (s_q.da == DBW'(DEB_CYC)) begin
      s_d.fa = s_q.sa[1];
      s_d.da = '0;
    end
    s_d.db = (s_q.sb[1] == s_q.fb) ? '0 : s_q.db + DBW'(1);
    if (s_q.db == DBW'(DEB_CYC)) begin
      s_d.fb = s_q.sb[1];
      s_d.db = '0;
    end
    // Count lines and control levels keep separate history so no edge is lost.
    s_d.lvl = {raw_a, raw_b, act_lvl};
    // Counter.
    if (do_clr) begin
      s_d.count = clr_val;
      s_d.passed = 1'b0;
    end else if (!inhibit) begin
      if (up && !(load_mode == 1'b0 && s_q.count == PRESET_MAX)) begin
        s_d.count = (s_q.count == PRESET_MAX) ? 24'h00_0000 : s_q.count + 24'h00_0001;
        if (!load_mode && s_d.count == s_q.preset[23:0]) begin
          s_d.passed = 1'b1;
        end
      end else if (dn) begin
        s_d.count = (s_q.count == 24'h00_0000) ? PRESET_MAX : s_q.count - 24'h00_0001;
        if (load_mode && s_q.count == 24'h00_0001) begin
          s_d.passed = 1'b1;
        end
      end
    end
    s_d.chk = (s_q.chk == 32'h0000_0000) ? CHK_CYC - 1 : s_q.chk - 32'h0000_0001;
    if (coin) begin
      s_d.passed = 1'b0;
    end
    // Hundredth-second tick for pulsed outputs.
    s_d.hund = (s_q.tick == 24'h00_0000);
    s_d.tick = s_d.hund ? 24'(TICK_CYC - 1) : s_q.tick - 24'h00_0001;
    // Outputs.
    for (int o = 0; o < 3; o++) begin
      ev = 2'b00;
      for (int k = 0; k < 3; k++) begin
        if ((k == 0 && coin) || (k == 1 && octl) || (k == 2 && do_clr && !coin)) begin
          if (s_q.ocfg[o][OUT_COIN_LSB + 2*k +: 2] == PCC_ACT_PICK) ev[0] = 1'b1;
          if (s_q.ocfg[o][OUT_COIN_LSB + 2*k +: 2] == PCC_ACT_DROP) ev[1] = 1'b1;
        end
      end
      if (s_q.ocfg[o][OUT_REV_BIT]) begin
        ev = {ev[0], ev[1]};
      end
      if (ev[0] && !s_q.on[o]) begin
        s_d.on[o] = 1'b1;
        s_d.dur[o] = s_q.ocfg[o][OUT_DUR_LSB +: 14];
      end else if (ev[1]) begin
        s_d.on[o] = 1'b0;
      end else if (s_q.ocfg[o][OUT_PUL_BIT] && s_q.on[o] && s_q.hund) begin
        s_d.dur[o] = s_q.dur[o] - 14'h0001;
        if (s_q.dur[o] <= 14'h0001) begin
          s_d.on[o] = 1'b0;
        end
      end
    end
    // Program mode entry.
    s_d.win = s_q.win - 32'h0000_0001;
    unique case (s_q.pst)
      PCC_RUN: begin
        if (s_q.sr[1]) begin
          s_d.pst = PCC_ARMED;
          s_d.win = ENTER_CYC - 1;
        end
      end
      PCC_ARMED: begin
        if (s_q.se[1]) begin
          s_d.pst = PCC_PROG;
        end else if (s_q.win == 32'h0000_0000) begin
          s_d.pst = PCC_RUN;
        end
      end
      PCC_PROG: begin
        s_d.on = 3'b000;
        if (s_q.sr[1] && !s_q.se[1]) begin
          s_d.pst = PCC_RUN;
        end
      end
      default: s_d.pst = PCC_RUN;
    endcase
    // Serial message gating and turnaround.
    if (msg_valid && !s_q.busy && msg_id == s_q.serial[SER_ID_LSB +: 8]) begin
      s_d.busy = 1'b1;
      s_d.turn = s_q.serial[SER_TURN_BIT] ? 24'(TLONG_CYC - 1) : 24'(TSHORT_CYC - 1);
    end else if (s_q.busy) begin
      if (s_q.turn == 24'h00_0000) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.turn = s_q.turn - 24'h00_0001;
      end
    end
    // APB access; acted on once, in the first cycle of the two-cycle access phase.
    if (rd) begin
      unique case (paddr)
        REG_MODE:    s_d.rdata = s_q.mode;
        REG_INPUTS:  s_d.rdata = s_q.inputs;
        REG_OUTCFG0: s_d.rdata = s_q.ocfg[0];
        REG_OUTCFG1: s_d.rdata = s_q.ocfg[1];
        REG_OUTCFG2: s_d.rdata = s_q.ocfg[2];
        REG_PRESET:  s_d.rdata = s_q.preset;
        REG_SERIAL:  s_d.rdata = s_q.serial;
        REG_COUNT:   s_d.rdata = {8'h00, s_q.count};
        REG_STATUS:  s_d.rdata = {24'h00_0000, s_q.refused, lockall, lock,
                                  program_mode, s_q.on, s_q.passed};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.err = 1'b1;
        end
      endcase
    end
    if (wr) begin
      s_d.refused = 1'b0;
      unique case (paddr)
        REG_MODE, REG_INPUTS, REG_OUTCFG0, REG_OUTCFG1, REG_OUTCFG2, REG_SERIAL: begin
          if (prog_ok) begin
            if (paddr == REG_MODE)    s_d.mode = pwdata & 32'h0000_073F;
            if (paddr == REG_INPUTS)  s_d.inputs = pwdata & 32'h0000_7777;
            if (paddr == REG_OUTCFG0) s_d.ocfg[0] = pwdata;
            if (paddr == REG_OUTCFG1) s_d.ocfg[1] = pwdata;
            if (paddr == REG_OUTCFG2) s_d.ocfg[2] = pwdata;
            if (paddr == REG_SERIAL && pwdata[7:0] <= 8'(ID_MAX)) s_d.serial = pwdata;
          end else begin
            s_d.refused = 1'b1;
            s_d.err = 1'b1;
          end
        end
        REG_PRESET: begin
          if (preset_ok && pwdata[23:0] <= PRESET_MAX) begin
            s_d.preset = {8'h00, pwdata[23:0]};
          end else begin
            s_d.refused = 1'b1;
            s_d.err = 1'b1;
          end
        end
        default: s_d.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= RST_MODE;
      s_q.ocfg <= {RST_OUTCFG, RST_OUTCFG, RST_OUTCFG};
      s_q.on <= 3'b000;
      s_q.pst <= PCC_RUN;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
